// ==== rtl/i2c_link_pkg.sv ====
// Purpose: Shared constants for the two-wire serial link, device and master ends.
// Assumes: 125 MHz system clock on both ends; open-drain wires resolved outside.
// Notes: The device address is a parameter; only its default, 7'h5A, is fixed here.
package i2c_link_pkg;
    localparam int CLK_MHZ = 125;
    localparam int BIT_RATE_KBPS = 100;
    // A quarter SCL period in system cycles, rounded down.
    localparam int QUARTER_CYC = (CLK_MHZ * 1000) / (BIT_RATE_KBPS * 4);
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5A;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
endpackage

// ==== rtl/i2c_link_if.sv ====
// Purpose: Carrier of the two open-drain wires between master and device.
// Assumes: A pullup makes each wire high when nobody pulls it low.
// Notes: Wired-AND is resolved from the enables here.
`timescale 1ns/100ps
interface i2c_link_if;
    logic scl_m_oe;
    logic sda_m_oe;
    logic sda_d_oe;
    logic scl;
    logic sda;
    // Open drain: an enabled driver always pulls low.
    assign scl = ~scl_m_oe;
    assign sda = ~(sda_m_oe | sda_d_oe);
    modport master (output scl_m_oe, output sda_m_oe, input scl, input sda);
    modport device (output sda_d_oe, input scl, input sda);
endinterface

// ==== rtl/i2c_link_device.sv ====
// Purpose: Slave end: detects bus conditions, shifts bytes, acknowledges.
// Assumes: SCL and SDA come from another domain and are synchronised here.
// Notes: Command validity and read data come from the user side.
`timescale 1ns/100ps
module i2c_link_device #(
    parameter logic [6:0] DEV_ADDR = i2c_link_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    i2c_link_if.device link,
    input wire logic busy_in,
    input wire logic cmd_ok_in,
    input wire logic [7:0] rd_data_in,
    output logic rd_take_out,
    output logic [7:0] wr_data_out,
    output logic wr_valid_out,
    output logic wr_is_cmd_out,
    output logic start_out,
    output logic stop_out,
    output logic sel_read_out
);
    import i2c_link_pkg::*;

    ////////////////////////////////////////////////////////////////
    // State map: idle waits for START, address and receive shift bits in,
    // acknowledge holds the slot, transmit shifts bits out, and the slot
    // of the master's acknowledge decides whether another read byte follows.
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_RX, S_TX, S_ACK, S_MACK} state_t;

    // Everything this end remembers lives in one record, so the reset value
    // and the next-state copy can never drift apart field by field.
    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic scl_q;
        logic sda_q;
        state_t st;
        state_t after_ack;
        logic [2:0] cnt;
        logic [7:0] sh;
        logic first_data;
        logic refuse;
        logic drive_low;
        logic ack_pend;
        logic [7:0] wdata;
        logic wvalid;
        logic wcmd;
        logic take;
        logic start_p;
        logic stop_p;
        logic rd_dir;
    } dev_t;

    dev_t r_reg, r_next;
    logic scl_n, sda_n, scl_rise, scl_fall, start_c, stop_c;

    ////////////////////////////////////////////////////////////////
    // The wires pass three flip-flops; a level counts only when the last
    // two agree, which rejects a one-cycle glitch at the cost of about four
    // cycles of latency. The master's quarter count must stay well above
    // that latency, or this end would act on a stale bit.
    always_comb begin
        r_next = r_reg;
        r_next.scl_s = {r_reg.scl_s[1:0], link.scl};
        r_next.sda_s = {r_reg.sda_s[1:0], link.sda};
        // A change counts only when stages two and three agree.
        scl_n = (r_reg.scl_s[1] == r_reg.scl_s[2]) ? r_reg.scl_s[2] : r_reg.scl_q;
        sda_n = (r_reg.sda_s[1] == r_reg.sda_s[2]) ? r_reg.sda_s[2] : r_reg.sda_q;
        r_next.scl_q = scl_n;
        r_next.sda_q = sda_n;
        scl_rise = scl_n & ~r_reg.scl_q;
        scl_fall = ~scl_n & r_reg.scl_q;
        start_c = r_reg.scl_q & scl_n & r_reg.sda_q & ~sda_n;
        stop_c = r_reg.scl_q & scl_n & ~r_reg.sda_q & sda_n;
        r_next.wvalid = 1'b0;
        r_next.take = 1'b0;
        r_next.start_p = start_c;
        r_next.stop_p = stop_c;
        if (start_c) begin
            // Repeated START restarts address reception at once.
            r_next.st = S_ADDR;
            r_next.cnt = 3'h0;
            r_next.drive_low = 1'b0;
        end else if (stop_c) begin
            r_next.st = S_IDLE;
            r_next.drive_low = 1'b0;
        end else begin
            case (r_reg.st)
                S_IDLE: begin
                    r_next.drive_low = 1'b0;
                end
                S_ADDR, S_RX: begin
                    if (scl_rise) begin
                        r_next.sh = {r_reg.sh[6:0], sda_n};
                        r_next.cnt = r_reg.cnt + 3'h1;
                        r_next.ack_pend = (r_reg.cnt == BIT_LAST);
                    end
                    // The decision is taken on the fall that ends the eighth bit,
                    // so the acknowledge level stands a whole low phase before
                    // the ninth rise.
                    if (scl_fall && r_reg.ack_pend) begin
                        r_next.ack_pend = 1'b0;
                        r_next.st = S_ACK;
                        if (r_reg.st == S_ADDR) begin
                            // Busy or foreign address: SDA stays released.
                            r_next.refuse = busy_in || (r_reg.sh[7:1] != DEV_ADDR);
                            r_next.rd_dir = r_reg.sh[0];
                            r_next.first_data = (r_reg.sh[0] == DIR_WRITE);
                            r_next.after_ack = (r_reg.sh[0] == DIR_READ) ? S_TX : S_RX;
                        end else begin
                            r_next.refuse = r_reg.first_data && !cmd_ok_in;
                            r_next.wdata = r_reg.sh;
                            r_next.wvalid = 1'b1;
                            r_next.wcmd = r_reg.first_data;
                            r_next.first_data = 1'b0;
                            r_next.after_ack = S_RX;
                        end
                        r_next.drive_low = 1'b1;
                        if (r_reg.st == S_ADDR) begin
                            r_next.drive_low = !(busy_in || (r_reg.sh[7:1] != DEV_ADDR));
                        end else if (r_reg.first_data && !cmd_ok_in) begin
                            r_next.drive_low = 1'b0;
                        end
                    end
                end
                S_ACK: begin
                    // Low is held across the whole high phase; the fall releases it or launches the first read bit.
                    if (scl_fall) begin
                        if (r_reg.refuse) begin
                            r_next.st = S_IDLE;
                            r_next.drive_low = 1'b0;
                        end else if (r_reg.after_ack == S_TX) begin
                            r_next.st = S_TX;
                            r_next.sh = rd_data_in;
                            r_next.take = 1'b1;
                            r_next.cnt = 3'h0;
                            r_next.drive_low = ~rd_data_in[7];
                        end else begin
                            r_next.st = S_RX;
                            r_next.cnt = 3'h0;
                            r_next.drive_low = 1'b0;
                        end
                    end
                end
                S_TX: begin
                    // Each bit is launched on the detected fall, so it settles
                    // well before the master samples it in the high phase.
                    if (scl_fall) begin
                        r_next.cnt = r_reg.cnt + 3'h1;
                        if (r_reg.cnt == BIT_LAST) begin
                            r_next.st = S_MACK;
                            r_next.drive_low = 1'b0;
                        end else begin
                            r_next.sh = {r_reg.sh[6:0], 1'b0};
                            r_next.drive_low = ~r_reg.sh[6];
                        end
                    end
                end
                S_MACK: begin
                    // SDA is released here; the master alone decides this slot,
                    // and a high level at the rise means no further byte.
                    if (scl_rise) begin
                        // No acknowledge from the master ends the read.
                        r_next.refuse = sda_n;
                    end
                    if (scl_fall) begin
                        if (r_reg.refuse) begin
                            r_next.st = S_IDLE;
                            r_next.drive_low = 1'b0;
                        end else begin
                            r_next.st = S_TX;
                            r_next.sh = rd_data_in;
                            r_next.take = 1'b1;
                            r_next.cnt = 3'h0;
                            r_next.drive_low = ~rd_data_in[7];
                        end
                    end
                end
                default: r_next.st = S_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Reset releases SDA and presets the filters to the idle high level,
    // so no false edge or START is seen when reset ends.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r_reg <= '{scl_s: 3'h7, sda_s: 3'h7, scl_q: 1'b1, sda_q: 1'b1,
                       st: S_IDLE, after_ack: S_IDLE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Open drain: the enable pulls the wire low and nothing drives it high.
    // A limitation: read data is taken on the fall that ends an acknowledge
    // slot, so the user side must have the next byte ready by then.
    assign link.sda_d_oe = r_reg.drive_low;
    assign wr_data_out = r_reg.wdata;
    assign wr_valid_out = r_reg.wvalid;
    assign wr_is_cmd_out = r_reg.wcmd;
    assign rd_take_out = r_reg.take;
    assign start_out = r_reg.start_p;
    assign stop_out = r_reg.stop_p;
    assign sel_read_out = r_reg.rd_dir;
endmodule

// ==== rtl/i2c_link_master.sv ====
// Purpose: Master end: makes SCL, START, STOP, sends and reads bytes.
// Assumes: No clock stretching; SCL is driven only by this end.
// Notes: One byte per request; the user chains bytes and ends with STOP.
`timescale 1ns/100ps
module i2c_link_master #(
    parameter int QUARTER = i2c_link_pkg::QUARTER_CYC
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    i2c_link_if.master link,
    input wire logic req_in,
    input wire logic req_start_in,
    input wire logic req_stop_in,
    input wire logic req_read_in,
    input wire logic req_nack_in,
    input wire logic [7:0] req_data_in,
    output logic ready_out,
    output logic done_out,
    output logic [7:0] rd_data_out,
    output logic acked_out
);
    import i2c_link_pkg::*;

    typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} mstate_t;

    typedef struct packed {
        logic [2:0] sda_s;
        logic sda_q;
        mstate_t st;
        logic [15:0] div;
        logic [1:0] ph;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rd;
        logic nack;
        logic stop;
        logic scl_low;
        logic sda_low;
        logic done;
        logic acked;
        logic [7:0] rdata;
    } mst_t;

    mst_t r_reg, r_next;
    logic tick, sda_n;

    ////////////////////////////////////////////////////////////////
    always_comb begin
        r_next = r_reg;
        r_next.sda_s = {r_reg.sda_s[1:0], link.sda};
        sda_n = (r_reg.sda_s[1] == r_reg.sda_s[2]) ? r_reg.sda_s[2] : r_reg.sda_q;
        r_next.sda_q = sda_n;
        r_next.done = 1'b0;
        tick = (r_reg.div == 16'(QUARTER - 1));
        r_next.div = tick ? 16'h0000 : r_reg.div + 16'h0001;
        case (r_reg.st)
            M_IDLE: begin
                r_next.div = 16'h0000;
                if (req_in) begin
                    r_next.sh = req_data_in;
                    r_next.rd = req_read_in;
                    r_next.nack = req_nack_in;
                    r_next.stop = req_stop_in;
                    r_next.cnt = 4'h0;
                    r_next.ph = 2'h0;
                    // A fresh START needs an idle bus; repeated START follows a held SCL low.
                    r_next.st = req_start_in ? M_START : M_BIT;
                end
            end
            M_START: if (tick) begin
                r_next.ph = r_reg.ph + 2'h1;
                case (r_reg.ph)
                    2'h0: r_next.sda_low = 1'b0;
                    2'h1: r_next.scl_low = 1'b0;
                    2'h2: r_next.sda_low = 1'b1;
                    default: begin
                        r_next.scl_low = 1'b1;
                        r_next.st = M_BIT;
                    end
                endcase
            end
            M_BIT, M_ACK: if (tick) begin
                // Phases: 0 set SDA with SCL low, 1 raise, 2 sample, 3 fall.
                r_next.ph = r_reg.ph + 2'h1;
                case (r_reg.ph)
                    2'h0: begin
                        if (r_reg.st == M_BIT) begin
                            r_next.sda_low = r_reg.rd ? 1'b0 : ~r_reg.sh[7];
                        end else begin
                            r_next.sda_low = r_reg.rd && !r_reg.nack;
                        end
                    end
                    2'h1: r_next.scl_low = 1'b0;
                    2'h2: begin
                        if (r_reg.st == M_BIT) begin
                            r_next.sh = {r_reg.sh[6:0], sda_n};
                        end else begin
                            r_next.acked = r_reg.rd ? !r_reg.nack : !sda_n;
                        end
                    end
                    default: begin
                        r_next.scl_low = 1'b1;
                        if (r_reg.st == M_ACK) begin
                            r_next.st = r_reg.stop ? M_STOP : M_IDLE;
                            r_next.rdata = r_reg.sh;
                            r_next.done = ~r_reg.stop;
                            r_next.sda_low = r_reg.stop;
                        end else if (r_reg.cnt == 4'h7) begin
                            r_next.st = M_ACK;
                        end else begin
                            r_next.cnt = r_reg.cnt + 4'h1;
                        end
                    end
                endcase
            end
            M_STOP: if (tick) begin
                r_next.ph = r_reg.ph + 2'h1;
                case (r_reg.ph)
                    2'h0: r_next.sda_low = 1'b1;
                    2'h1: r_next.scl_low = 1'b0;
                    2'h2: r_next.sda_low = 1'b0;
                    default: begin
                        r_next.st = M_IDLE;
                        r_next.done = 1'b1;
                    end
                endcase
            end
            default: r_next.st = M_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            r_reg <= '{sda_s: 3'h7, sda_q: 1'b1, st: M_IDLE, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.scl_m_oe = r_reg.scl_low;
    assign link.sda_m_oe = r_reg.sda_low;
    assign ready_out = (r_reg.st == M_IDLE);
    assign done_out = r_reg.done;
    assign rd_data_out = r_reg.rdata;
    assign acked_out = r_reg.acked;
endmodule

// ==== sim/i2c_link_asserts.sv ====
// Purpose: Protocol checks on the two shared wires of the link.
// Assumes: Wires are sampled on the system clock of both ends.
// Notes: Phase minimums follow the master's quarter count.
`timescale 1ns/100ps
module i2c_link_asserts #(
    parameter int QUARTER = i2c_link_pkg::QUARTER_CYC
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic scl_m_oe,
    input wire logic sda_m_oe,
    input wire logic sda_d_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [15:0] hi_reg;
    logic [15:0] lo_reg;
    // Counters saturate so a long idle bus cannot wrap them.
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hi_reg <= 16'h0;
            lo_reg <= 16'h0;
        end else begin
            hi_reg <= scl ? hi_reg + {15'h0, ~&hi_reg} : 16'h0;
            lo_reg <= !scl ? lo_reg + {15'h0, ~&lo_reg} : 16'h0;
        end
    end
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////////////////////////////
    a_dev_pull_low: assert property ($rose(sda_d_oe) |-> !scl)
        else $error("device pulled SDA while SCL high");
    a_dev_free_low: assert property ($fell(sda_d_oe) |-> !scl)
        else $error("device released SDA while SCL high");
    a_dev_hold_high: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
        else $error("device SDA changed in SCL high phase");
    a_ack_held_low: assert property ($rose(scl) && sda_d_oe |-> sda_d_oe [*4])
        else $error("device low bit not held after SCL rise");
    a_start_dev_free: assert property ($fell(sda) && scl && $past(scl) |-> !sda_d_oe)
        else $error("device drives SDA at a START");
    a_stop_dev_quiet: assert property ($rose(sda) && scl && $past(scl) |=> !sda_d_oe [*4])
        else $error("device drives SDA after a STOP");
    a_scl_high_min: assert property ($fell(scl) |-> hi_reg >= 16'(QUARTER))
        else $error("SCL high phase too short");
    a_scl_low_min: assert property ($rose(scl) |-> lo_reg >= 16'(QUARTER))
        else $error("SCL low phase too short");
    c_start: cover property ($fell(sda) && scl && $past(scl));
    c_stop: cover property ($rose(sda) && scl && $past(scl));
    c_dev_ack: cover property ($rose(scl) && sda_d_oe);
    c_mst_low: cover property ($rose(scl) && sda_m_oe && !scl_m_oe);
endmodule

// ==== sim/testbench.sv ====
// Purpose: Master and device ends joined; byte transfers with expected results.
// Assumes: Short quarter count so each byte takes a few hundred cycles.
// Notes: Device read data steps by 8'h11 at each byte it takes in read mode.
`timescale 1ns/100ps
module testbench;
    import i2c_link_pkg::*;
    localparam int QUARTER = 10;
    localparam logic [6:0] ADDR = DEV_ADDR_DEFAULT;
    logic clk_sys_in, nrst_in, req, st, sp, rd, nk, busy, cmd_ok;
    logic ready, done, acked, take, wr_valid, wr_cmd, start_p, stop_p, sel_rd;
    logic [7:0] dat, rd_data_in, mst_rd, wr_data;
    int err_count, checked, n_start, n_stop;
    logic [8:0] wq[$];
    i2c_link_if link();
    i2c_link_master #(.QUARTER(QUARTER)) u_i2c_link_master (.clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in), .link(link.master), .req_in(req), .req_start_in(st),
        .req_stop_in(sp), .req_read_in(rd), .req_nack_in(nk), .req_data_in(dat),
        .ready_out(ready), .done_out(done), .rd_data_out(mst_rd), .acked_out(acked));
    i2c_link_device #(.DEV_ADDR(ADDR)) u_i2c_link_device (.clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in), .link(link.device), .busy_in(busy), .cmd_ok_in(cmd_ok),
        .rd_data_in(rd_data_in), .rd_take_out(take), .wr_data_out(wr_data),
        .wr_valid_out(wr_valid), .wr_is_cmd_out(wr_cmd), .start_out(start_p),
        .stop_out(stop_p), .sel_read_out(sel_rd));
    i2c_link_asserts #(.QUARTER(QUARTER)) u_i2c_link_asserts (.clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in), .scl_m_oe(link.scl_m_oe), .sda_m_oe(link.sda_m_oe),
        .sda_d_oe(link.sda_d_oe), .scl(link.scl), .sda(link.sda));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // One process owns the counters and the device's read data.
    always @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            n_start <= 0;
            n_stop <= 0;
            rd_data_in <= 8'h96;
        end else begin
            if (wr_valid === 1'b1) wq.push_back({wr_cmd, wr_data});
            if (start_p === 1'b1) n_start <= n_start + 1;
            if (stop_p === 1'b1) n_stop <= n_stop + 1;
            if (take === 1'b1 && sel_rd === 1'b1) rd_data_in <= rd_data_in + 8'h11;
        end
    end
    task automatic end_of_test();
        $display("Counts: %0d compares, %0d mismatches", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One byte through the master; the wait for the answer is bounded.
    task automatic op(input logic s, p, r, n, input logic [7:0] d, input logic ea);
        int k;
        @(posedge clk_sys_in);
        req <= 1'b1;
        st <= s;
        sp <= p;
        rd <= r;
        nk <= n;
        dat <= d;
        k = 0;
        do begin
            @(posedge clk_sys_in);
            k++;
        end while (ready !== 1'b1 && k < 100);
        req <= 1'b0;
        while (done !== 1'b1 && k < 3000) begin
            @(posedge clk_sys_in);
            k++;
        end
        if (k >= 3000) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, 1'b0, 1'b1);
            end_of_test();
        end
        chk(9'(acked), 9'(ea));
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {nrst_in, req, st, sp, rd, nk, busy} = 7'h00;
        cmd_ok = 1'b1;
        dat = 8'h00;
        {err_count, checked} = {2{32'sh0}};
        repeat (20) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        op(1, 0, 0, 0, {ADDR, DIR_WRITE}, 1);
        chk(9'(sel_rd), 9'(DIR_WRITE));
        op(0, 0, 0, 0, 8'hA5, 1);
        op(0, 1, 0, 0, 8'h3C, 1);
        chk(9'(wq.size()), 9'h002);
        chk(wq.pop_front(), 9'h1A5);
        chk(wq.pop_front(), 9'h03C);
        $display("write test ended");
        op(1, 0, 0, 0, {ADDR, DIR_WRITE}, 1);
        op(0, 0, 0, 0, 8'h44, 1);
        op(1, 0, 0, 0, {ADDR, DIR_READ}, 1);
        chk(9'(sel_rd), 9'(DIR_READ));
        op(0, 0, 1, 0, 8'h00, 1);
        chk(9'(mst_rd), 9'h096);
        op(0, 1, 1, 1, 8'h00, 0);
        chk(9'(mst_rd), 9'h0A7);
        $display("read test ended");
        op(1, 1, 0, 0, {ADDR ^ 7'h01, DIR_WRITE}, 0);
        busy <= 1'b1;
        op(1, 1, 0, 0, {ADDR, DIR_WRITE}, 0);
        busy <= 1'b0;
        $display("refused address test ended");
        cmd_ok <= 1'b0;
        op(1, 0, 0, 0, {ADDR, DIR_WRITE}, 1);
        op(0, 0, 0, 0, 8'hFF, 0);
        op(0, 1, 0, 0, 8'h12, 0);
        cmd_ok <= 1'b1;
        op(1, 0, 0, 0, {ADDR, DIR_WRITE}, 1);
        op(0, 1, 0, 0, 8'h5E, 1);
        chk(9'(n_start), 9'h007);
        chk(9'(n_stop), 9'h006);
        $display("refused command test ended");
        end_of_test();
    end
endmodule
